//--- hdl/msync_pkg.sv
// How it works
// - The reference pin is sampled by clk_sys, the converter clock over 4.
// - Skip count zero: the first sampled rising edge after arming syncs.
// - After arming, skip-count edges are dropped; the next edge syncs.
// - Subclass 1: edges off the multiframe clock after sync raise jitter.
// - Window is bits 5:0, low two bits ignored; zero means half a cycle.
// - Arming drops link sync requests; rotation done raises them again.
// - Subclass comes from bits 7:5 of 0x458; only 0 and 1 are supported.
// - Subclass 0 needs no reference activity; both channels stay aligned.
// - Each local multiframe clock lags the aligned one by the delay.
// - Receive buffer holds data for the release delay plus one cycle, 1 to 13 cycles.
// - Frame clocks per processing cycle equal 4 over octets per frame.
// - Rotation done flag sets on sync and holds until a new sync request.
// - Subclass 0 aligns on an internal processing clock edge instead.
package msync_pkg;
  localparam int          NUM_LINKS      = 2;
  localparam int          ADDR_W         = 12;
  localparam int          PH_W           = 7;
  localparam int          REL_MAX        = 12;
  localparam int          FRAMES_PER_MF  = 32;
  localparam int          OCTETS_PER_PCLK = 4;

  localparam logic [11:0] ADDR_SKIP      = 12'h036;
  localparam logic [11:0] ADDR_WINDOW    = 12'h039;
  localparam logic [11:0] ADDR_ONESHOT   = 12'h03a;
  localparam logic [11:0] ADDR_SYNC_EN   = 12'h03b;
  localparam logic [11:0] ADDR_LMF_DELAY = 12'h304;
  localparam logic [11:0] ADDR_REL_DELAY = 12'h306;
  localparam logic [11:0] ADDR_SUBCLASS  = 12'h458;

  localparam int          ARM_BIT        = 1;
  localparam int          DONE_BIT       = 4;
  localparam int          JITTER_BIT     = 5;
  localparam int          EN_BIT         = 0;
  localparam int          RAMP_BIT       = 1;
  localparam int          SC_LSB         = 5;
  localparam int          SC_MSB         = 7;
  localparam int          WIN_LSB        = 2;
  localparam int          WIN_MSB        = 5;
  localparam logic [2:0]  SUBCLASS_1     = 3'h1;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  DELAY_CAP      = 8'h0c;

  typedef enum logic [1:0] {
    SYNC_IDLE  = 2'b00,
    SYNC_ARMED = 2'b01,
    SYNC_DONE  = 2'b11
  } sync_state_t;
endpackage

//--- hdl/ref_sync2.sv
`timescale 1ns/1ps
module ref_sync2 (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // ref_sync2

//--- hdl/release_delay.sv
`timescale 1ns/1ps
module release_delay
  import msync_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Delay setting and data-ready strobe
  input  wire logic [3:0] delay_sel,
  input  wire logic       ready_in,
  // Delayed ready, taken from a register
  output logic            release_out
);
  // Tap k holds ready_in delayed by k+1 cycles; tap selection plus the
  // output register gives exactly delay_sel+1 cycles from input to output.
  logic [REL_MAX-1:0] taps_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      taps_r      <= '0;
      release_out <= 1'b0;
    end else begin
      taps_r <= {taps_r[REL_MAX-2:0], ready_in};
      if (delay_sel == 4'h0) begin
        release_out <= ready_in;
      end else begin
        release_out <= taps_r[delay_sel - 4'h1];
      end
    end
  end
endmodule // release_delay

//--- hdl/multiframe_sync_latency_ctrl.sv
`timescale 1ns/1ps
module multiframe_sync_latency_ctrl
  import msync_pkg::*;
(
  // Clock and reset; clk_sys is the converter clock divided by 4
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Register port
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  // Alignment reference pin and link mode
  input  wire logic                 sysref_in,
  input  wire logic [3:0]           octets_per_frame,
  input  wire logic                 rx_data_ready,
  // Link side outputs
  output logic [NUM_LINKS-1:0]      link_sync_request_out_n,
  output logic [NUM_LINKS-1:0]      per_link_frame_clock_delay,
  output logic                      aligned_mf_clock,
  output logic                      alignment_jitter_irq,
  output logic                      datapath_ramp,
  output logic                      buffer_release
);

  typedef struct packed {
    logic [7:0]           skip;
    logic [7:0]           window;
    logic                 arm;
    logic                 done;
    logic                 jitter;
    logic [7:0]           sync_en;
    logic [7:0]           lmf_delay;
    logic [7:0]           rel_delay;
    logic [7:0]           subclass_reg;
    sync_state_t          state;
    logic [7:0]           skip_left;
    logic [PH_W-1:0]      phase;
    logic                 ref_prev;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [NUM_LINKS-1:0] link_n;
    logic [NUM_LINKS-1:0] local_mf;
    logic                 mf;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       ref_s;
  logic [3:0] rel_sel;

  // The reference pin is asynchronous to clk_sys and is synchronised.
  ref_sync2 u_ref_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (sysref_in),
    .sync_out (ref_s)
  );

  // Oversized settings are clamped, so a bad write cannot index past the
  // delay line; keeping it in range is still software's job.
  assign rel_sel = (st_r.rel_delay > DELAY_CAP) ? DELAY_CAP[3:0]
                                                : st_r.rel_delay[3:0];

  release_delay u_release (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .delay_sel   (rel_sel),
    .ready_in    (rx_data_ready),
    .release_out (buffer_release)
  );

  logic            subclass1;
  logic [PH_W-1:0] period;
  logic [PH_W-1:0] last_phase;
  logic [PH_W-1:0] dev;
  logic [PH_W-1:0] dev_alt;
  logic            ref_edge;
  logic            align_evt;
  logic            arm_rise;
  logic            wr_oneshot;

  always_comb begin
    st_nxt     = st_r;
    subclass1  = (st_r.subclass_reg[SC_MSB:SC_LSB] == SUBCLASS_1);
    // Cycles per multiframe = frames per multiframe / (4 / F).
    period     = PH_W'((FRAMES_PER_MF / OCTETS_PER_PCLK)
                       * int'(octets_per_frame));
    last_phase = period - PH_W'(1);
    ref_edge   = ref_s & ~st_r.ref_prev;
    // Subclass 0 (and unsupported codes) align on the internal clock edge.
    align_evt  = subclass1 ? ref_edge : 1'b1;
    wr_oneshot = reg_wr && (reg_addr == ADDR_ONESHOT);
    arm_rise   = wr_oneshot && reg_wdata[ARM_BIT] && !st_r.arm
                 && st_r.sync_en[EN_BIT];
    dev        = st_r.phase;
    dev_alt    = period - st_r.phase;

    st_nxt.ref_prev = ref_s;
    st_nxt.rvalid   = reg_rd;
    st_nxt.rdata    = REG_RESET;

    // Free-running multiframe phase counter.
    if (st_r.phase >= last_phase) begin
      st_nxt.phase = '0;
    end else begin
      st_nxt.phase = st_r.phase + PH_W'(1);
    end

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        ADDR_SKIP:      st_nxt.skip         = reg_wdata;
        ADDR_WINDOW:    st_nxt.window       = reg_wdata;
        ADDR_ONESHOT:   st_nxt.arm          = reg_wdata[ARM_BIT];
        ADDR_SYNC_EN:   st_nxt.sync_en      = reg_wdata;
        ADDR_LMF_DELAY: st_nxt.lmf_delay    = reg_wdata;
        ADDR_REL_DELAY: st_nxt.rel_delay    = reg_wdata;
        ADDR_SUBCLASS:  st_nxt.subclass_reg = reg_wdata;
        default:        st_nxt.arm          = st_r.arm;
      endcase
    end

    // One-shot sync sequencer.
    case (st_r.state)
      SYNC_IDLE, SYNC_DONE: begin
        if (arm_rise) begin
          st_nxt.state     = SYNC_ARMED;
          st_nxt.done      = 1'b0;
          st_nxt.jitter    = 1'b0;
          st_nxt.skip_left = st_r.skip;
          st_nxt.link_n    = '0;
        end else if (st_r.state == SYNC_DONE && subclass1 && ref_edge) begin
          // Deviation in divided-clock units, nearest multiframe boundary.
          if (dev_alt < dev) begin
            dev = dev_alt;
          end
          if (dev > PH_W'(st_r.window[WIN_MSB:WIN_LSB])) begin
            st_nxt.jitter = 1'b1;
          end
        end
      end
      SYNC_ARMED: begin
        if (!st_r.sync_en[EN_BIT] ||
            (wr_oneshot && !reg_wdata[ARM_BIT])) begin
          st_nxt.state  = SYNC_IDLE;
        end else if (align_evt) begin
          if (subclass1 && st_r.skip_left != 8'h00) begin
            st_nxt.skip_left = st_r.skip_left - 8'h01;
          end else begin
            // Reload so the next wrap lands one multiframe after this edge.
            st_nxt.phase  = PH_W'(1);
            st_nxt.state  = SYNC_DONE;
            st_nxt.done   = 1'b1;
            st_nxt.link_n = '1;
          end
        end
      end
      default: st_nxt.state = SYNC_IDLE;
    endcase

    // Multiframe clocks: aligned one at phase zero, local ones delayed.
    st_nxt.mf = (st_nxt.phase == '0);
    for (int i = 0; i < NUM_LINKS; i++) begin
      st_nxt.local_mf[i] = (st_nxt.phase ==
                            st_r.lmf_delay[PH_W-1:0]);
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    if (reg_rd) begin
      case (reg_addr)
        ADDR_SKIP:      st_nxt.rdata = st_r.skip;
        ADDR_WINDOW:    st_nxt.rdata = st_r.window;
        ADDR_ONESHOT: begin
          st_nxt.rdata[ARM_BIT]    = st_r.arm;
          st_nxt.rdata[DONE_BIT]   = st_r.done;
          st_nxt.rdata[JITTER_BIT] = st_r.jitter;
        end
        ADDR_SYNC_EN:   st_nxt.rdata = st_r.sync_en;
        ADDR_LMF_DELAY: st_nxt.rdata = st_r.lmf_delay;
        ADDR_REL_DELAY: st_nxt.rdata = st_r.rel_delay;
        ADDR_SUBCLASS:  st_nxt.rdata = st_r.subclass_reg;
        default:        st_nxt.rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{skip: REG_RESET, window: REG_RESET, arm: 1'b0, done: 1'b0,
                jitter: 1'b0, sync_en: REG_RESET, lmf_delay: REG_RESET,
                rel_delay: REG_RESET, subclass_reg: REG_RESET,
                state: SYNC_IDLE, skip_left: REG_RESET, phase: '0,
                ref_prev: 1'b0, rdata: REG_RESET, rvalid: 1'b0,
                link_n: '1, local_mf: '0, mf: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                  = st_r.rdata;
  assign reg_rvalid                 = st_r.rvalid;
  assign link_sync_request_out_n    = st_r.link_n;
  assign per_link_frame_clock_delay = st_r.local_mf;
  assign aligned_mf_clock           = st_r.mf;
  assign alignment_jitter_irq       = st_r.jitter;
  assign datapath_ramp              = st_r.sync_en[RAMP_BIT];

endmodule // multiframe_sync_latency_ctrl

//--- tb/msync_monitor.sv
`timescale 1ns/1ps
module msync_monitor
  import msync_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  // Register port
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [ADDR_W-1:0]    reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 reg_rvalid,
  // Pins and link side
  input wire logic                 sysref_in,
  input wire logic [3:0]           octets_per_frame,
  input wire logic                 rx_data_ready,
  input wire logic [NUM_LINKS-1:0] link_sync_request_out_n,
  input wire logic [NUM_LINKS-1:0] per_link_frame_clock_delay,
  input wire logic                 aligned_mf_clock,
  input wire logic                 alignment_jitter_irq,
  input wire logic                 datapath_ramp,
  input wire logic                 buffer_release
);
  logic        arm_wr;
  logic        rel_wr;
  logic        run_r;
  logic [7:0]  gap_r;
  logic [7:0]  rel_r;
  logic [3:0]  quiet_r;
  logic [12:0] hist_r;
  logic [3:0]  dsel;
  assign arm_wr = reg_wr && reg_addr == ADDR_ONESHOT && reg_wdata[ARM_BIT];
  assign rel_wr = reg_wr && reg_addr == ADDR_REL_DELAY;
  assign dsel = (rel_r > DELAY_CAP) ? 4'hc : rel_r[3:0];
  // The period is only judged between two pulses with the links up, so a
  // resync never shows up as a short multiframe.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_r   <= 1'b0;
      gap_r   <= 8'h00;
      rel_r   <= 8'h00;
      quiet_r <= 4'h0;
      hist_r  <= 13'h0000;
    end else begin
      run_r   <= &link_sync_request_out_n && (run_r || aligned_mf_clock);
      gap_r   <= aligned_mf_clock ? 8'h00 : gap_r + 8'h01;
      rel_r   <= rel_wr ? reg_wdata : rel_r;
      quiet_r <= rel_wr ? 4'h0 : quiet_r + 4'(quiet_r != 4'hf);
      hist_r  <= {hist_r[11:0], rx_data_ready};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence rd_req;
    reg_rd;
  endsequence
  sequence rd_ans;
    reg_rvalid;
  endsequence
  read_answer_a: assert property (rd_req |=> rd_ans)
    else $error("read not answered next cycle");
  read_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  link_drop_a: assert property (
    $fell(link_sync_request_out_n[0]) |-> $past(arm_wr))
    else $error("links dropped without an arm write");
  links_paired_a: assert property (
    link_sync_request_out_n[0] == link_sync_request_out_n[1])
    else $error("link requests disagree");
  jitter_sticky_a: assert property (
    $fell(alignment_jitter_irq) |-> $past(arm_wr))
    else $error("jitter flag cleared without an arm");
  ramp_source_a: assert property (
    $changed(datapath_ramp) |-> $past(reg_wr && reg_addr == ADDR_SYNC_EN))
    else $error("ramp changed without an enable write");
  mf_period_a: assert property (
    aligned_mf_clock && run_r
      |-> gap_r == 8'({octets_per_frame, 3'b000}) - 8'h01)
    else $error("multiframe period wrong");
  release_delay_a: assert property (
    quiet_r == 4'hf |-> buffer_release == hist_r[dsel])
    else $error("buffer release delay wrong");
endmodule // msync_monitor

bind multiframe_sync_latency_ctrl msync_monitor u_msync_monitor (
  .clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_rvalid, .sysref_in, .octets_per_frame, .rx_data_ready,
  .link_sync_request_out_n, .per_link_frame_clock_delay, .aligned_mf_clock,
  .alignment_jitter_irq, .datapath_ramp, .buffer_release);

//--- tb/sysref_source.sv
`timescale 1ns/1ps
module sysref_source #(
  parameter int HOLD = 2
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Pulse request and reference pin
  input  wire logic fire,
  output logic      sysref_in
);
  logic [3:0] left_r;
  // Two sampling cycles is eight converter clocks, safely over the minimum.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_r <= 4'h0;
    end else if (fire) begin
      left_r <= 4'(HOLD);
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  assign sysref_in = left_r != 4'h0;
endmodule // sysref_source

//--- tb/tb_multiframe_sync_latency_ctrl.sv
`timescale 1ns/1ps
module tb_multiframe_sync_latency_ctrl;
  import msync_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fire = 1'b0, rx_data_ready = 1'b0, sysref_in, reg_rvalid;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [3:0] octets_per_frame = 4'h2;
  logic [NUM_LINKS-1:0] link_sync_request_out_n, per_link_frame_clock_delay;
  logic aligned_mf_clock, alignment_jitter_irq, datapath_ramp, buffer_release;
  logic [11:0] regs [7];
  int err_count = 0, comparisons = 0, cyc = 0, n;
  multiframe_sync_latency_ctrl u_multiframe_sync_latency_ctrl (
    .clk_sys, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .sysref_in, .octets_per_frame, .rx_data_ready,
    .link_sync_request_out_n, .per_link_frame_clock_delay, .aligned_mf_clock,
    .alignment_jitter_irq, .datapath_ramp, .buffer_release);
  sysref_source u_sysref_source (.clk_sys, .resetn, .fire, .sysref_in);
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rx_data_ready <= 1'($urandom_range(0, 1));
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // Expected one-shot control readback from the arm, done and jitter bits.
  function automatic logic [7:0] oneshot_exp(input logic armed,
                                             input logic done,
                                             input logic jit);
    logic [7:0] v;
    v             = 8'h00;
    v[ARM_BIT]    = armed;
    v[DONE_BIT]   = done;
    v[JITTER_BIT] = jit;
    return v;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("register %h", a), e, reg_rdata);
  endtask
  // Pulse spacing is k + 2 cycles from one request to the next.
  task automatic pulse(input int k);
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic arm();
    wr(ADDR_ONESHOT, 8'h00);
    wr(ADDR_ONESHOT, 8'h02);
  endtask
  initial begin
    void'($urandom(86928));
    regs = '{ADDR_SKIP, ADDR_WINDOW, ADDR_ONESHOT, ADDR_SYNC_EN,
             ADDR_LMF_DELAY, ADDR_REL_DELAY, ADDR_SUBCLASS};
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (regs[i]) rchk(regs[i], REG_RESET);
    chk("links", 8'h03, 8'(link_sync_request_out_n));
    foreach (regs[i]) begin
      if (i != 2) begin
        d = 8'($urandom);
        wr(regs[i], d);
        rchk(regs[i], d);
      end
    end
    wr(12'h100, 8'($urandom));
    rchk(12'h100, 8'h00);
    wr(ADDR_SYNC_EN, 8'hf3);
    repeat (2) @(posedge clk_sys);
    #1 chk("ramp", 8'h01, 8'(datapath_ramp));
    wr(ADDR_SYNC_EN, 8'hf1);
    repeat (2) @(posedge clk_sys);
    #1 chk("ramp", 8'h00, 8'(datapath_ramp));
    wr(ADDR_SUBCLASS, 8'h00);
    wr(ADDR_REL_DELAY, DELAY_CAP);
    d = 8'($urandom_range(0, 15));
    wr(ADDR_LMF_DELAY, d);
    arm();
    repeat (3) @(posedge clk_sys);
    rchk(ADDR_ONESHOT, oneshot_exp(1'b1, 1'b1, 1'b0));
    for (n = 0; n < 40 && aligned_mf_clock !== 1'b1; n++)
      @(posedge clk_sys) #1;
    for (n = 0; n < 40 && per_link_frame_clock_delay[0] !== 1'b1; n++)
      @(posedge clk_sys) #1;
    chk("frame clock delay", d, 8'(n));
    chk("local clocks", 8'h03, 8'(per_link_frame_clock_delay));
    wr(ADDR_SUBCLASS, 8'h20);
    wr(ADDR_WINDOW, 8'h07);
    wr(ADDR_SKIP, 8'h03);
    arm();
    repeat (3) pulse(10);
    chk("links", 8'h00, 8'(link_sync_request_out_n));
    rchk(ADDR_ONESHOT, oneshot_exp(1'b1, 1'b0, 1'b0));
    pulse(14);
    chk("links", 8'h03, 8'(link_sync_request_out_n));
    pulse(18);
    chk("jitter", 8'h00, 8'(alignment_jitter_irq));
    pulse(8);
    chk("jitter", 8'h01, 8'(alignment_jitter_irq));
    rchk(ADDR_ONESHOT, oneshot_exp(1'b1, 1'b1, 1'b1));
    arm();
    repeat (2) @(posedge clk_sys);
    #1 chk("jitter", 8'h00, 8'(alignment_jitter_irq));
    chk("links", 8'h00, 8'(link_sync_request_out_n));
    wr(ADDR_REL_DELAY, 8'($urandom_range(0, 12)));
    repeat (40) @(posedge clk_sys);
    // Clearing the arm bit while armed abandons the sync; links stay down.
    wr(ADDR_ONESHOT, 8'h00);
    rchk(ADDR_ONESHOT, oneshot_exp(1'b0, 1'b0, 1'b0));
    chk("links", 8'h00, 8'(link_sync_request_out_n));
    conclude();
  end
endmodule // tb_multiframe_sync_latency_ctrl
